/* design/phy_mii_pkg.sv */
// constants and carrier types for the mii port and strap block
package phy_mii_pkg;

    // register indices (the address port carries the index itself)
    localparam logic [4:0] STRAP_CFG_IDX = 5'h10;
    localparam logic [4:0] ADDR_CFG_IDX  = 5'h11;
    localparam logic [4:0] XFER_CFG_IDX  = 5'h12;
    localparam logic [4:0] MODE_CTRL_IDX = 5'h14;
    localparam logic [4:0] STATUS_IDX    = 5'h15;

    // field positions
    localparam int BLOCK_BP_BIT = 15;
    localparam int SCR_BP_BIT   = 14;
    localparam int ALIGN_BP_BIT = 13;
    localparam int REPEATER_BIT = 11;
    localparam int ADDR_MSB     = 8;
    localparam int ADDR_LSB     = 4;
    localparam int SERIAL_BIT   = 10;
    localparam int SPEED_BIT    = 0;
    localparam int FDX_BIT      = 1;
    localparam int ST_CRS_BIT   = 0;
    localparam int ST_ISO_BIT   = 1;
    localparam int ST_TEST_BIT  = 2;
    localparam int ST_RXDV_BIT  = 3;
    localparam int ST_TXEN_BIT  = 4;
    localparam int ST_SER_BIT   = 5;

    // reset values
    localparam logic       SPEED_RST   = 1'b1;
    localparam logic       FDX_RST     = 1'b0;
    localparam logic [4:0] ADDR_RST    = 5'h00;
    localparam logic [4:0] ISOLATE_ADR = 5'h00;
    localparam logic [15:0] RDATA_RST  = 16'h0000;

    typedef struct packed {
        logic       repeater_node_select;
        logic       align_bypass_strap;
        logic       block_code_bypass_strap;
        logic       scrambler_bypass_strap;
        logic       serial_10m_select;
        logic [4:0] phy_address_straps;
    } strap_type;

    typedef struct packed {
        logic [4:0] symbol;
        logic       active;
        logic       valid;
        logic       err;
    } line_rx_type;

    typedef struct packed {
        logic [3:0] data;
        logic       en;
        logic       force_invalid;
        logic       serial;
        logic       bypass_align;
        logic       bypass_block;
        logic       bypass_scr;
    } line_tx_type;

    typedef struct packed {
        logic       tx_clk;
        logic       rx_clk;
        logic [3:0] rxd;
        logic       rx_dv;
        logic       rx_er;
        logic       crs;
    } mii_out_type;

    typedef struct packed {
        logic        reset_n;
        strap_type   straps;
        logic        output_float_control;
        logic        factory_test_select;
        logic        link_clk;
        line_rx_type line_rx;
        logic        tx_en;
        logic        tx_er;
        logic [3:0]  txd;
    } async_in_type;

    typedef struct packed {
        logic       repeater;
        logic       align_bp;
        logic       block_bp;
        logic       scr_bp;
        logic       serial;
        logic [4:0] addr_field;
        logic       speed100;
        logic       fdx;
    } cfg_type;

endpackage

/* design/phy_mii_port.sv */
// mii port, strap capture, carrier sense and output float control
`timescale 1ns/100ps
`default_nettype none

module phy_mii_port (
    input  wire logic                        CLK,
    input  wire logic                        SYS_RST,
    input  wire logic                        RESET_N,
    input  wire phy_mii_pkg::strap_type      STRAPS,
    input  wire logic                        OUTPUT_FLOAT_CONTROL,
    input  wire logic                        FACTORY_TEST_SELECT,
    input  wire logic                        OSC_IN,
    input  wire logic                        LINK_CLK,
    input  wire phy_mii_pkg::line_rx_type    LINE_RX,
    input  wire logic                        TX_EN,
    input  wire logic                        TX_ER,
    input  wire logic [3:0]                  TXD,
    output var  phy_mii_pkg::mii_out_type    MII_OUT,
    output logic                             MII_OE,
    output logic                             CRYSTAL_CLOCK_OUT,
    output logic                             CRYSTAL_CLOCK_OUT_OE,
    output var  phy_mii_pkg::line_tx_type    LINE_TX,
    output logic                             TEST_MODE_EN,
    input  wire logic [4:0]                  REG_ADDR,
    input  wire logic [15:0]                 REG_WDATA,
    input  wire logic                        REG_WR,
    input  wire logic                        REG_RD,
    output logic [15:0]                      REG_RDATA
);

    // bit order of the address field is reversed against the strap bus
    function automatic logic [4:0] reverse5(input logic [4:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 5; i++) begin
            r[i] = v[4 - i];
        end
        return r;
    endfunction

    function automatic logic hit(input logic [4:0] a, input logic [4:0] idx);
        return a == idx;
    endfunction

    // input synchroniser
    phy_mii_pkg::async_in_type async_in;
    phy_mii_pkg::async_in_type sync1_r;
    phy_mii_pkg::async_in_type sync2_r;
    phy_mii_pkg::async_in_type sync1_nxt;
    phy_mii_pkg::async_in_type sync2_nxt;

    always_comb begin
        async_in.reset_n              = RESET_N;
        async_in.straps               = STRAPS;
        async_in.output_float_control = OUTPUT_FLOAT_CONTROL;
        async_in.factory_test_select  = FACTORY_TEST_SELECT;
        async_in.link_clk             = LINK_CLK;
        async_in.line_rx              = LINE_RX;
        async_in.tx_en                = TX_EN;
        async_in.tx_er                = TX_ER;
        async_in.txd                  = TXD;
        sync1_nxt                     = async_in;
        sync2_nxt                     = sync1_r;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    // link clock edge finder
    logic lk_prev_r;
    logic lk_prev_nxt;
    logic lk_rise;
    logic lk_fall;

    always_comb begin
        lk_prev_nxt = sync2_r.link_clk;
        lk_rise     = sync2_r.link_clk & ~lk_prev_r;
        lk_fall     = ~sync2_r.link_clk & lk_prev_r;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            lk_prev_r <= 1'b0;
        end else begin
            lk_prev_r <= lk_prev_nxt;
        end
    end

    // configuration registers
    phy_mii_pkg::cfg_type cfg_r;
    phy_mii_pkg::cfg_type cfg_nxt;
    logic [15:0]          rdata_r;
    logic [15:0]          rdata_nxt;
    logic                 isolate;
    logic                 serial_eff;
    logic                 bypass100;
    logic                 crs_r;
    logic                 tx_act_r;

    always_comb begin
        cfg_nxt = cfg_r;
        if (!sync2_r.reset_n) begin
            cfg_nxt.repeater   = sync2_r.straps.repeater_node_select;
            cfg_nxt.align_bp   = sync2_r.straps.align_bypass_strap;
            cfg_nxt.block_bp   = sync2_r.straps.block_code_bypass_strap;
            cfg_nxt.scr_bp     = sync2_r.straps.scrambler_bypass_strap;
            cfg_nxt.serial     = sync2_r.straps.serial_10m_select;
            cfg_nxt.addr_field = reverse5(sync2_r.straps.phy_address_straps);
            cfg_nxt.speed100   = phy_mii_pkg::SPEED_RST;
            cfg_nxt.fdx        = phy_mii_pkg::FDX_RST;
        end else if (REG_WR) begin
            // held values change only by software after release
            if (hit(REG_ADDR, phy_mii_pkg::STRAP_CFG_IDX)) begin
                cfg_nxt.repeater = REG_WDATA[phy_mii_pkg::REPEATER_BIT];
                cfg_nxt.align_bp = REG_WDATA[phy_mii_pkg::ALIGN_BP_BIT];
                cfg_nxt.block_bp = REG_WDATA[phy_mii_pkg::BLOCK_BP_BIT];
                cfg_nxt.scr_bp   = REG_WDATA[phy_mii_pkg::SCR_BP_BIT];
            end else if (hit(REG_ADDR, phy_mii_pkg::ADDR_CFG_IDX)) begin
                cfg_nxt.addr_field = REG_WDATA[phy_mii_pkg::ADDR_MSB:phy_mii_pkg::ADDR_LSB];
            end else if (hit(REG_ADDR, phy_mii_pkg::XFER_CFG_IDX)) begin
                cfg_nxt.serial = REG_WDATA[phy_mii_pkg::SERIAL_BIT];
            end else if (hit(REG_ADDR, phy_mii_pkg::MODE_CTRL_IDX)) begin
                cfg_nxt.speed100 = REG_WDATA[phy_mii_pkg::SPEED_BIT];
                cfg_nxt.fdx      = REG_WDATA[phy_mii_pkg::FDX_BIT];
            end
        end
    end

    always_comb begin
        rdata_nxt = phy_mii_pkg::RDATA_RST;
        if (REG_RD) begin
            if (hit(REG_ADDR, phy_mii_pkg::STRAP_CFG_IDX)) begin
                rdata_nxt[phy_mii_pkg::REPEATER_BIT] = cfg_r.repeater;
                rdata_nxt[phy_mii_pkg::ALIGN_BP_BIT] = cfg_r.align_bp;
                rdata_nxt[phy_mii_pkg::BLOCK_BP_BIT] = cfg_r.block_bp;
                rdata_nxt[phy_mii_pkg::SCR_BP_BIT]   = cfg_r.scr_bp;
            end else if (hit(REG_ADDR, phy_mii_pkg::ADDR_CFG_IDX)) begin
                rdata_nxt[phy_mii_pkg::ADDR_MSB:phy_mii_pkg::ADDR_LSB] = cfg_r.addr_field;
            end else if (hit(REG_ADDR, phy_mii_pkg::XFER_CFG_IDX)) begin
                rdata_nxt[phy_mii_pkg::SERIAL_BIT] = cfg_r.serial;
            end else if (hit(REG_ADDR, phy_mii_pkg::MODE_CTRL_IDX)) begin
                rdata_nxt[phy_mii_pkg::SPEED_BIT] = cfg_r.speed100;
                rdata_nxt[phy_mii_pkg::FDX_BIT]   = cfg_r.fdx;
            end else if (hit(REG_ADDR, phy_mii_pkg::STATUS_IDX)) begin
                rdata_nxt[phy_mii_pkg::ST_CRS_BIT]  = crs_r;
                rdata_nxt[phy_mii_pkg::ST_ISO_BIT]  = isolate;
                rdata_nxt[phy_mii_pkg::ST_TEST_BIT] = sync2_r.factory_test_select;
                rdata_nxt[phy_mii_pkg::ST_RXDV_BIT] = MII_OUT.rx_dv;
                rdata_nxt[phy_mii_pkg::ST_TXEN_BIT] = tx_act_r;
                rdata_nxt[phy_mii_pkg::ST_SER_BIT]  = serial_eff;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg_r   <= '0;
            rdata_r <= phy_mii_pkg::RDATA_RST;
        end else begin
            cfg_r   <= cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // mode decode
    always_comb begin
        isolate    = reverse5(cfg_r.addr_field) == phy_mii_pkg::ISOLATE_ADR;
        serial_eff = cfg_r.serial & ~cfg_r.speed100;
        bypass100  = cfg_r.speed100 & (cfg_r.align_bp | cfg_r.block_bp);
    end

    // mii datapath
    phy_mii_pkg::mii_out_type mii_r;
    phy_mii_pkg::mii_out_type mii_nxt;
    phy_mii_pkg::line_tx_type ltx_r;
    phy_mii_pkg::line_tx_type ltx_nxt;
    logic                     crs_nxt;
    logic                     tx_act_nxt;

    always_comb begin
        mii_nxt        = mii_r;
        ltx_nxt        = ltx_r;
        tx_act_nxt     = tx_act_r;
        // both clocks follow the sampled line clock without pause
        mii_nxt.tx_clk = sync2_r.link_clk;
        mii_nxt.rx_clk = sync2_r.link_clk;
        if (lk_fall) begin
            // receive outputs move on the falling clock edge
            if (serial_eff) begin
                mii_nxt.rxd = {3'h0, sync2_r.line_rx.symbol[0]};
            end else begin
                mii_nxt.rxd = sync2_r.line_rx.symbol[3:0];
            end
            mii_nxt.rx_dv = sync2_r.line_rx.valid;
            if (bypass100) begin
                mii_nxt.rx_er = sync2_r.line_rx.symbol[4];
            end else begin
                mii_nxt.rx_er = sync2_r.line_rx.err & sync2_r.line_rx.valid;
            end
            // transmit inputs are taken mid period, away from their edge
            tx_act_nxt            = sync2_r.tx_en;
            ltx_nxt.en            = sync2_r.tx_en;
            ltx_nxt.data          = serial_eff ? {3'h0, sync2_r.txd[0]} : sync2_r.txd;
            ltx_nxt.force_invalid = sync2_r.tx_en & sync2_r.tx_er;
        end
        ltx_nxt.serial       = serial_eff;
        ltx_nxt.bypass_align = cfg_r.speed100 & cfg_r.align_bp;
        ltx_nxt.bypass_block = cfg_r.speed100 & cfg_r.block_bp;
        ltx_nxt.bypass_scr   = cfg_r.speed100 & cfg_r.scr_bp;
        if (cfg_r.repeater || cfg_r.fdx) begin
            crs_nxt = sync2_r.line_rx.active;
        end else begin
            crs_nxt = sync2_r.line_rx.active | tx_act_r;
        end
        mii_nxt.crs = crs_nxt;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            mii_r    <= '0;
            ltx_r    <= '0;
            crs_r    <= 1'b0;
            tx_act_r <= 1'b0;
        end else begin
            mii_r    <= mii_nxt;
            ltx_r    <= ltx_nxt;
            crs_r    <= crs_nxt;
            tx_act_r <= tx_act_nxt;
        end
    end

    // outputs
    always_comb begin
        MII_OUT              = mii_r;
        LINE_TX              = ltx_r;
        REG_RDATA            = rdata_r;
        MII_OE               = ~sync2_r.output_float_control & ~isolate;
        CRYSTAL_CLOCK_OUT    = OSC_IN;
        CRYSTAL_CLOCK_OUT_OE = ~sync2_r.output_float_control;
        TEST_MODE_EN         = sync2_r.factory_test_select;
    end

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence release_seen;
        $rose(sync2_r.reset_n);
    endsequence

    sequence tx_err_taken;
        lk_fall && sync2_r.tx_en && sync2_r.tx_er;
    endsequence

    repeater_capture_a: assert property (
        release_seen |-> cfg_r.repeater == $past(sync2_r.straps.repeater_node_select))
        else $error("repeater strap not held");
    align_capture_a: assert property (
        release_seen |-> cfg_r.align_bp == $past(sync2_r.straps.align_bypass_strap))
        else $error("align strap not held");
    block_capture_a: assert property (
        release_seen |-> cfg_r.block_bp == $past(sync2_r.straps.block_code_bypass_strap))
        else $error("block strap not held");
    scr_capture_a: assert property (
        release_seen |-> cfg_r.scr_bp == $past(sync2_r.straps.scrambler_bypass_strap))
        else $error("scrambler strap not held");
    serial_capture_a: assert property (
        release_seen |-> cfg_r.serial == $past(sync2_r.straps.serial_10m_select))
        else $error("serial strap not held");
    addr_capture_a: assert property (
        release_seen |->
            cfg_r.addr_field[4] == $past(sync2_r.straps.phy_address_straps[0]))
        else $error("address bit order wrong");
    addr_order_a: assert property (
        release_seen |-> reverse5(cfg_r.addr_field) == $past(sync2_r.straps.phy_address_straps))
        else $error("address field not captured");
    strap_hold_a: assert property (
        $past(sync2_r.reset_n) && !$past(REG_WR) |-> $stable(cfg_r))
        else $error("held configuration moved");
    isolate_oe_a: assert property (
        cfg_r.addr_field == 5'h00 |-> !MII_OE)
        else $error("zero address not isolated");
    float_oe_a: assert property (
        sync2_r.output_float_control |-> !MII_OE && !CRYSTAL_CLOCK_OUT_OE)
        else $error("outputs driven while floated");
    crystal_pass_a: assert property (
        CRYSTAL_CLOCK_OUT == OSC_IN)
        else $error("crystal clock not passed");
    test_select_a: assert property (
        TEST_MODE_EN == $past(sync1_r.factory_test_select))
        else $error("test select not followed");
    rx_fall_a: assert property (
        $changed(MII_OUT.rxd) |-> $past(lk_fall))
        else $error("receive data moved off falling edge");
    rx_hold_a: assert property (
        !lk_fall |=> $stable(MII_OUT.rxd) && $stable(MII_OUT.rx_dv))
        else $error("receive outputs moved between falls");
    serial_rxd_a: assert property (
        lk_fall && serial_eff |=> MII_OUT.rxd[3:1] == 3'h0)
        else $error("serial mode drove upper data");
    serial_tx_a: assert property (
        lk_fall && serial_eff |=> LINE_TX.data[3:1] == 3'h0)
        else $error("serial mode took upper data");
    serial_100m_a: assert property (
        cfg_r.speed100 |=> !LINE_TX.serial)
        else $error("serial used at 100M");
    nibble_rxd_a: assert property (
        lk_fall && !serial_eff |=> MII_OUT.rxd == $past(sync2_r.line_rx.symbol[3:0]))
        else $error("nibble lost");
    rx_dv_a: assert property (
        lk_fall |=> MII_OUT.rx_dv == $past(sync2_r.line_rx.valid))
        else $error("rx valid not following frame");
    rx_err_a: assert property (
        lk_fall && !bypass100 |=> MII_OUT.rx_er ==
            ($past(sync2_r.line_rx.err) && $past(sync2_r.line_rx.valid)))
        else $error("rx error not marked");
    bypass_er_a: assert property (
        lk_fall && bypass100 |=> MII_OUT.rx_er == $past(sync2_r.line_rx.symbol[4]))
        else $error("bypass error bit wrong");
    tx_take_a: assert property (
        lk_fall |=> LINE_TX.en == $past(sync2_r.tx_en))
        else $error("tx enable not taken");
    tx_nibble_a: assert property (
        lk_fall && !serial_eff |=> LINE_TX.data == $past(sync2_r.txd))
        else $error("tx nibble not taken");
    tx_invalid_a: assert property (
        tx_err_taken |=> LINE_TX.force_invalid && LINE_TX.en)
        else $error("tx error not marked");
    crs_rx_only_a: assert property (
        (cfg_r.repeater || cfg_r.fdx) && !sync2_r.line_rx.active |=> !MII_OUT.crs)
        else $error("carrier without receive");
    crs_node_a: assert property (
        !cfg_r.repeater && !cfg_r.fdx && tx_act_r |=> MII_OUT.crs)
        else $error("carrier missing on transmit");
    tx_clk_a: assert property (
        MII_OUT.tx_clk == $past(sync2_r.link_clk) && MII_OUT.rx_clk == MII_OUT.tx_clk)
        else $error("mii clocks not following line clock");

endmodule

`default_nettype wire

/* verif/mii_mac_model.sv */
// behavioural mac model facing the mii port
`timescale 1ns/100ps
`default_nettype none

module mii_mac_model (
    input  wire phy_mii_pkg::mii_out_type mii,
    input  wire logic                     req_en,
    input  wire logic                     req_er,
    input  wire logic [3:0]               req_nib,
    output logic                          tx_en,
    output logic                          tx_er,
    output logic [3:0]                    txd,
    output logic [3:0]                    rx_last
);
    initial begin
        tx_en   = 1'b0;
        tx_er   = 1'b0;
        txd     = 4'h0;
        rx_last = 4'h0;
    end

    // transmit lines move just after the tx clock rises
    always @(posedge mii.tx_clk) begin
        tx_en <= req_en;
        tx_er <= req_er & req_en;
        txd   <= req_en ? req_nib : ~txd;
    end

    // receive nibble taken on the rx clock rise while valid
    always @(posedge mii.rx_clk) begin
        if (mii.rx_dv) begin
            rx_last <= mii.rxd;
        end
    end
endmodule

`default_nettype wire

/* verif/tb_phy_mii_port.sv */
// self-checking bench for the mii port and strap block
`timescale 1ns/100ps
`default_nettype none
`define CHECK_EQ(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("BAD t=%0t got %h exp %h", $time, (got), (exp)); \
    end \
end

module tb_phy_mii_port;
    logic                       clk;
    logic                       sys_rst;
    logic                       reset_n;
    phy_mii_pkg::strap_type     straps;
    logic                       float_ctl;
    logic                       test_sel;
    logic                       osc_in;
    logic                       link_clk;
    phy_mii_pkg::line_rx_type   line_rx;
    logic                       mac_en;
    logic                       mac_er;
    logic [3:0]                 mac_nib;
    logic                       tx_en;
    logic                       tx_er;
    logic [3:0]                 txd;
    logic [3:0]                 rx_last;
    phy_mii_pkg::mii_out_type   mii_out;
    logic                       mii_oe;
    logic                       xtal_out;
    logic                       xtal_oe;
    phy_mii_pkg::line_tx_type   line_tx;
    logic                       test_en;
    logic [4:0]                 reg_addr;
    logic [15:0]                reg_wdata;
    logic                       reg_wr;
    logic                       reg_rd;
    logic [15:0]                reg_rdata;
    logic [15:0]                rd;
    logic [7:0]                 rxc_cnt;
    logic [7:0]                 txc_cnt;
    logic [7:0]                 n0;
    logic [7:0]                 n1;
    logic                       rxc_q;
    logic                       txc_q;
    phy_mii_pkg::strap_type     pat [3];
    int                         err_total;
    int                         cmp_count;
    int                         cycles;

    phy_mii_port phy_mii_port_inst (
        .CLK(clk), .SYS_RST(sys_rst), .RESET_N(reset_n), .STRAPS(straps),
        .OUTPUT_FLOAT_CONTROL(float_ctl), .FACTORY_TEST_SELECT(test_sel),
        .OSC_IN(osc_in), .LINK_CLK(link_clk), .LINE_RX(line_rx),
        .TX_EN(tx_en), .TX_ER(tx_er), .TXD(txd), .MII_OUT(mii_out), .MII_OE(mii_oe),
        .CRYSTAL_CLOCK_OUT(xtal_out), .CRYSTAL_CLOCK_OUT_OE(xtal_oe), .LINE_TX(line_tx),
        .TEST_MODE_EN(test_en), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));

    mii_mac_model mii_mac_model_inst (
        .mii(mii_out), .req_en(mac_en), .req_er(mac_er), .req_nib(mac_nib),
        .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .rx_last(rx_last));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        link_clk = 1'b0;
        #7;
        forever #100 link_clk = ~link_clk;
    end

    // cycle count, timeout and rising edges of the mii clocks
    always @(posedge clk) begin
        cycles <= cycles + 1;
        rxc_q <= mii_out.rx_clk;
        txc_q <= mii_out.tx_clk;
        if (mii_out.rx_clk && !rxc_q) rxc_cnt <= rxc_cnt + 8'h01;
        if (mii_out.tx_clk && !txc_q) txc_cnt <= txc_cnt + 8'h01;
        if (cycles == 20000) begin
            err_total++;
            $display("BAD t=%0t timeout", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic test_end(input string name);
        $display("test %0s done", name);
    endtask

    task automatic reg_wr_t(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_rd_t(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // reset pin held low far shorter than on a board
    task automatic strap_reset(input phy_mii_pkg::strap_type s);
        @(posedge clk);
        straps  <= s;
        reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        straps  <= ~s;
    endtask

    task automatic check_straps(input phy_mii_pkg::strap_type s);
        logic [4:0]  a;
        logic [15:0] e;
        a = s.phy_address_straps;
        e = {s.block_code_bypass_strap, s.scrambler_bypass_strap, s.align_bypass_strap,
             1'b0, s.repeater_node_select, 11'h000};
        reg_rd_t(phy_mii_pkg::STRAP_CFG_IDX, rd);
        `CHECK_EQ(rd & 16'hE800, e)
        reg_rd_t(phy_mii_pkg::ADDR_CFG_IDX, rd);
        `CHECK_EQ(rd[8:4], {a[0], a[1], a[2], a[3], a[4]})
        reg_rd_t(phy_mii_pkg::XFER_CFG_IDX, rd);
        `CHECK_EQ(rd[10], s.serial_10m_select)
    endtask

    // one link period: inputs set after a rise, outputs seen after the fall
    task automatic link_step(input phy_mii_pkg::line_rx_type rx, input logic en,
                             input logic er, input logic [3:0] d);
        @(posedge link_clk);
        @(posedge clk);
        line_rx <= rx;
        mac_en  <= en;
        mac_er  <= er;
        mac_nib <= d;
        @(negedge link_clk);
        repeat (6) @(posedge clk);
        #1;
    endtask

    initial begin
        sys_rst = 1'b1;
        reset_n = 1'b1;
        straps = '0;
        float_ctl = 1'b0;
        test_sel = 1'b0;
        osc_in = 1'b0;
        line_rx = '0;
        mac_en = 1'b0;
        mac_er = 1'b0;
        mac_nib = 4'h0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_total = 0;
        cmp_count = 0;
        cycles = 0;
        rxc_cnt = 8'h00;
        txc_cnt = 8'h00;
        rxc_q = 1'b0;
        txc_q = 1'b0;
        pat[0] = {1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 5'h16};
        pat[1] = {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 5'h01};
        pat[2] = {1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00};
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            strap_reset(pat[p]);
            check_straps(pat[p]);
        end
        reg_rd_t(phy_mii_pkg::MODE_CTRL_IDX, rd);
        `CHECK_EQ(rd & 16'h0003, 16'h0001)
        reg_wr_t(5'h17, 16'hFFFF);
        reg_rd_t(5'h17, rd);
        `CHECK_EQ(rd, 16'h0000)
        test_end("straps");
        // repeater with bypass straps at 100M
        link_step({5'h15, 1'b1, 1'b1, 1'b0}, 1'b0, 1'b0, 4'h0);
        `CHECK_EQ({mii_out.rxd, mii_out.rx_dv, mii_out.rx_er}, 6'h17)
        link_step({5'h0A, 1'b1, 1'b1, 1'b1}, 1'b0, 1'b0, 4'h0);
        `CHECK_EQ({mii_out.rxd, mii_out.rx_er, rx_last}, 9'h145)
        link_step('0, 1'b1, 1'b0, 4'hC);
        `CHECK_EQ({mii_out.rx_dv, mii_out.crs}, 2'h0)
        `CHECK_EQ({line_tx.data, line_tx.en, line_tx.bypass_align}, 6'h33)
        `CHECK_EQ({line_tx.bypass_block, line_tx.bypass_scr}, 2'h3)
        reg_wr_t(phy_mii_pkg::MODE_CTRL_IDX, 16'h0000);
        link_step('0, 1'b1, 1'b0, 4'h3);
        `CHECK_EQ(line_tx[3:0], 4'h0)
        test_end("bypass");
        // node with serial strap
        strap_reset(pat[0]);
        check_straps(pat[0]);
        link_step({5'h1A, 1'b1, 1'b1, 1'b1}, 1'b0, 1'b0, 4'h0);
        `CHECK_EQ({mii_out.rxd, mii_out.rx_dv, mii_out.rx_er, line_tx.serial}, 7'h56)
        link_step({5'h13, 1'b1, 1'b1, 1'b0}, 1'b0, 1'b0, 4'h0);
        `CHECK_EQ({mii_out.rxd, mii_out.rx_er}, 5'h06)
        link_step('0, 1'b1, 1'b1, 4'h6);
        `CHECK_EQ({mii_out.rx_dv, mii_out.crs, line_tx.force_invalid}, 3'h3)
        `CHECK_EQ({line_tx.data, line_tx.en}, 5'h0D)
        link_step('0, 1'b1, 1'b0, 4'h9);
        `CHECK_EQ({line_tx.data, line_tx.force_invalid}, 5'h12)
        reg_wr_t(phy_mii_pkg::MODE_CTRL_IDX, 16'h0003);
        link_step('0, 1'b1, 1'b0, 4'h9);
        `CHECK_EQ(mii_out.crs, 1'b0)
        reg_wr_t(phy_mii_pkg::MODE_CTRL_IDX, 16'h0000);
        link_step({5'h0F, 1'b1, 1'b1, 1'b0}, 1'b0, 1'b0, 4'h0);
        `CHECK_EQ({mii_out.rxd, line_tx.serial, mii_out.crs}, 6'h07)
        link_step('0, 1'b0, 1'b0, 4'h0);
        `CHECK_EQ(mii_out.crs, 1'b0)
        #1;
        n0 = rxc_cnt;
        n1 = txc_cnt;
        repeat (40) @(posedge clk);
        #1;
        `CHECK_EQ(rxc_cnt - n0, 8'h05)
        `CHECK_EQ(txc_cnt - n1, 8'h05)
        test_end("link");
        // isolation, float, test select, crystal clock
        strap_reset(pat[2]);
        #1;
        `CHECK_EQ(mii_oe, 1'b0)
        reg_rd_t(phy_mii_pkg::STATUS_IDX, rd);
        `CHECK_EQ(rd[phy_mii_pkg::ST_ISO_BIT], 1'b1)
        reg_wr_t(phy_mii_pkg::ADDR_CFG_IDX, 16'h0100);
        repeat (2) @(posedge clk);
        #1;
        `CHECK_EQ({mii_oe, xtal_oe}, 2'h3)
        @(posedge clk);
        float_ctl <= 1'b1;
        test_sel <= 1'b1;
        osc_in <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHECK_EQ({mii_oe, xtal_oe, test_en, xtal_out}, 4'h3)
        reg_rd_t(phy_mii_pkg::STATUS_IDX, rd);
        `CHECK_EQ(rd[phy_mii_pkg::ST_TEST_BIT], 1'b1)
        @(posedge clk);
        float_ctl <= 1'b0;
        test_sel <= 1'b0;
        osc_in <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHECK_EQ({mii_oe, xtal_oe, test_en, xtal_out}, 4'hC)
        test_end("pins");
        tally_and_finish();
    end
endmodule

`default_nettype wire
